// ### usb_lowspeed_pkg.sv
// shared constants and types of the low-speed usb event and transmit control block
package usb_lowspeed_pkg;

	// ==================================================
	// register offsets on the cpu port
	localparam int          REG_ADDR_W       = 3;
	localparam logic [2:0]  OFF_EVENT_FLAGS  = 3'h0;
	localparam logic [2:0]  OFF_EVENT_MASK   = 3'h1;
	localparam logic [2:0]  OFF_LINK_CONTROL = 3'h2;
	localparam logic [2:0]  OFF_BUS_ID       = 3'h3;
	localparam logic [2:0]  OFF_ENDP_TX0     = 3'h4;
	localparam logic [2:0]  OFF_TOKEN_INFO   = 3'h7;
	localparam int          ENDP_COUNT       = 3;

	// ==================================================
	// event flag bit positions
	localparam int FLAG_SLEEP_REQ = 7;
	localparam int FLAG_DMA_LATE  = 6;
	localparam int FLAG_GOOD_XFER = 5;
	localparam int FLAG_ERROR     = 4;
	localparam int FLAG_IRQ_OVR   = 3;
	localparam int FLAG_WAKE      = 2;
	localparam int FLAG_BUS_RESET = 1;
	localparam int FLAG_FRAME     = 0;

	// ==================================================
	// link control bits and reset values
	localparam int CTL_RESUME       = 3;
	localparam int CTL_REGULATOR    = 2;
	localparam int CTL_FORCED_SLEEP = 1;
	localparam int CTL_FORCED_RESET = 0;
	localparam logic [7:0] EVENT_FLAGS_RST  = 8'h00;
	localparam logic [7:0] EVENT_MASK_RST   = 8'h00;
	localparam logic [3:0] LINK_CONTROL_RST = 4'h6;
	localparam logic [6:0] BUS_ID_RST       = 7'h00;
	localparam logic [7:0] ENDP_TX_RST      = 8'h00;

	// ==================================================
	// endpoint transmit register layout and codes
	localparam int ETX_STATUS_ONLY = 7;
	localparam int ETX_TOGGLE      = 6;
	localparam int ETX_STATE_HI    = 5;
	localparam int ETX_STATE_LO    = 4;
	localparam logic [1:0] TX_DISABLED = 2'h0;
	localparam logic [1:0] TX_STALL    = 2'h1;
	localparam logic [1:0] TX_NAK      = 2'h2;
	localparam logic [1:0] TX_VALID    = 2'h3;
	localparam logic [1:0] TOKEN_OUT   = 2'h0;
	localparam logic [1:0] TOKEN_IN    = 2'h2;
	localparam logic [1:0] TOKEN_SETUP = 2'h3;

	// ==================================================
	// timing
	localparam longint CLK_HZ          = 50000000;
	localparam longint SLEEP_IDLE_MS   = 3;
	localparam longint SLEEP_IDLE_CYC  = SLEEP_IDLE_MS * CLK_HZ / 1000;
	localparam int     IDLE_CNT_W      = 18;

	typedef enum logic [2:0] {
		HS_NONE,
		HS_STALL,
		HS_NAK,
		HS_DATA,
		HS_ACCEPT
	} handshake_t;

endpackage

// ### usb_lowspeed_ctrl.sv
// event flags, link control, bus id and endpoint transmit control of the low-speed usb function
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module usb_lowspeed_ctrl
	import usb_lowspeed_pkg::*;
#(
	parameter longint SLEEP_IDLE_CYCLES = SLEEP_IDLE_CYC
)
(
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	input  wire logic [2:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	input  wire logic              cpu_imask,
	input  wire logic              line_idle_pin,
	input  wire logic              bus_reset_seen,
	input  wire logic              keepalive_seen,
	input  wire logic              dma_late,
	input  wire logic              err_timeout,
	input  wire logic              err_crc,
	input  wire logic              err_stuff,
	input  wire logic              err_framing,
	input  wire logic              xfer_done,
	input  wire logic [1:0]        xfer_token,
	input  wire logic [1:0]        xfer_endp,
	input  wire logic [4:0]        xfer_faults,
	input  wire logic              xfer_toggle_ok,
	input  wire logic              xfer_refused,
	input  wire logic              setup_seen,
	input  wire logic [1:0]        setup_endp,
	input  wire logic              host_ack,
	input  wire logic [1:0]        ack_endp,
	input  wire logic              in_req,
	input  wire logic              out_req,
	input  wire logic [1:0]        req_endp,
	input  wire logic              out_nonzero,
	output handshake_t             hs_code,
	output logic                   hs_valid,
	output logic      [3:0]        tx_len,
	output logic                   tx_data_pid,
	output logic                   irq_req,
	output logic                   wake_irq,
	output logic                   resume_drive,
	output logic                   regulator_off,
	output logic                   link_asleep,
	output logic                   link_held_reset,
	output logic      [6:0]        bus_id
);

	// ==================================================
	// state
	logic [7:0]            event_flags;
	logic [7:0]            event_mask;
	logic [3:0]            link_control;
	logic [7:0]            endp_tx [ENDP_COUNT];
	logic [1:0]            token_type_bits;
	logic [1:0]            endpoint_number_bits;
	logic                  idle_s1;
	logic                  idle_s2;
	logic                  idle_s3;
	logic                  idle_lvl;
	logic [IDLE_CNT_W-1:0] idle_cnt;
	logic                  sleep_sent;
	logic                  check_on;
	logic                  resume_q;
	logic                  forced_reset_q;
	logic [7:0]            next_flags_set;
	logic                  usb_rst;
	logic                  good_ev;
	logic                  err_ev;
	logic                  frame_ev;
	logic                  wake_ev;
	logic                  sleep_ev;
	logic                  resume_end;
	logic                  forced_reset_end;
	logic                  wr_flags;
	logic                  wr_ctl;
	logic                  forced_sleep;
	logic [7:0]            req_reg;
	logic                  req_known;

	localparam logic [IDLE_CNT_W-1:0] IDLE_LIMIT = SLEEP_IDLE_CYCLES[IDLE_CNT_W-1:0];

	assign forced_sleep     = link_control[CTL_FORCED_SLEEP];
	assign wr_flags         = reg_wr && (reg_addr == OFF_EVENT_FLAGS);
	assign wr_ctl           = reg_wr && (reg_addr == OFF_LINK_CONTROL);
	assign usb_rst          = bus_reset_seen || link_control[CTL_FORCED_RESET];
	assign resume_end       = resume_q && !link_control[CTL_RESUME];
	assign forced_reset_end = forced_reset_q && !link_control[CTL_FORCED_RESET];

	// ==================================================
	// line activity synchroniser
	// the level only moves once the second and third stages agree
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			idle_s1  <= 1'b1;
			idle_s2  <= 1'b1;
			idle_s3  <= 1'b1;
			idle_lvl <= 1'b1;
		end
		else
		begin
			idle_s1 <= line_idle_pin;
			idle_s2 <= idle_s1;
			idle_s3 <= idle_s2;
			if (idle_s2 == idle_s3)
				idle_lvl <= idle_s3;
		end
	end

	// ==================================================
	// event detection
	assign good_ev  = xfer_done && (xfer_faults == 5'h00) && xfer_toggle_ok && !xfer_refused;
	assign err_ev   = err_timeout || err_crc || err_stuff || err_framing;
	assign frame_ev = keepalive_seen || resume_end;
	assign wake_ev  = forced_sleep && !idle_lvl;
	assign sleep_ev = check_on && idle_lvl && !usb_rst && (idle_cnt == IDLE_LIMIT) && !sleep_sent;

	always_comb
	begin
		next_flags_set                 = 8'h00;
		next_flags_set[FLAG_SLEEP_REQ] = sleep_ev;
		next_flags_set[FLAG_DMA_LATE]  = dma_late;
		next_flags_set[FLAG_GOOD_XFER] = good_ev;
		next_flags_set[FLAG_ERROR]     = err_ev;
		next_flags_set[FLAG_IRQ_OVR]   = (err_ev && event_flags[FLAG_ERROR]) ||
			(frame_ev && event_flags[FLAG_FRAME]);
		next_flags_set[FLAG_WAKE]      = wake_ev;
		next_flags_set[FLAG_BUS_RESET] = bus_reset_seen || forced_reset_end;
		next_flags_set[FLAG_FRAME]     = frame_ev;
	end

	// a write only ever ands the flags down; a hardware set in the same cycle still lands
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			event_flags <= EVENT_FLAGS_RST;
		else if (wr_flags)
			event_flags <= (event_flags & reg_wdata) | next_flags_set;
		else
			event_flags <= event_flags | next_flags_set;
	end

	// token and endpoint freeze while a good transfer is still unacknowledged
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			token_type_bits      <= 2'h0;
			endpoint_number_bits <= 2'h0;
		end
		else if (good_ev && !event_flags[FLAG_GOOD_XFER])
		begin
			token_type_bits      <= xfer_token;
			endpoint_number_bits <= xfer_endp;
		end
	end

	// ==================================================
	// idle watch for the sleep request
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			check_on <= 1'b1;
		else if (usb_rst || resume_end)
			check_on <= 1'b1;
		else if (wr_ctl && reg_wdata[CTL_FORCED_SLEEP] && !forced_sleep)
			check_on <= 1'b0;
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			idle_cnt   <= '0;
			sleep_sent <= 1'b0;
		end
		else if (!check_on || !idle_lvl || usb_rst)
		begin
			idle_cnt   <= '0;
			sleep_sent <= 1'b0;
		end
		else
		begin
			if (idle_cnt != IDLE_LIMIT)
				idle_cnt <= idle_cnt + 1'b1;
			if (sleep_ev)
				sleep_sent <= 1'b1;
		end
	end

	// ==================================================
	// link control
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			link_control <= LINK_CONTROL_RST;
		else
		begin
			if (wr_ctl)
				link_control <= reg_wdata[3:0];
			if (wake_ev)
				link_control[CTL_FORCED_SLEEP] <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			resume_q       <= 1'b0;
			forced_reset_q <= 1'b0;
		end
		else
		begin
			resume_q       <= link_control[CTL_RESUME];
			forced_reset_q <= link_control[CTL_FORCED_RESET];
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			resume_drive    <= 1'b0;
			regulator_off   <= 1'b1;
			link_asleep     <= 1'b1;
			link_held_reset <= 1'b0;
		end
		else
		begin
			resume_drive    <= link_control[CTL_RESUME];
			regulator_off   <= link_control[CTL_REGULATOR];
			link_asleep     <= forced_sleep;
			link_held_reset <= usb_rst;
		end
	end

	// ==================================================
	// mask and interrupt request
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			event_mask <= EVENT_MASK_RST;
		else if (reg_wr && (reg_addr == OFF_EVENT_MASK))
			event_mask <= reg_wdata;
	end

	// the wake line ignores the cpu mask so it can still end a halt
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			irq_req  <= 1'b0;
			wake_irq <= 1'b0;
		end
		else
		begin
			irq_req  <= (|(event_flags & event_mask)) && !cpu_imask;
			wake_irq <= event_flags[FLAG_WAKE] && event_mask[FLAG_WAKE];
		end
	end

	// ==================================================
	// bus id
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			bus_id <= BUS_ID_RST;
		else if (usb_rst)
			bus_id <= BUS_ID_RST;
		else if (reg_wr && (reg_addr == OFF_BUS_ID))
			bus_id <= reg_wdata[6:0];
	end

	// ==================================================
	// endpoint transmit registers; hardware updates land after a same-cycle write
	for (genvar i = 0; i < ENDP_COUNT; i++)
	begin : g_endp
		localparam logic [1:0] IDX = 2'(i);
		always_ff @(posedge sys_clk or posedge sys_rst)
		begin
			if (sys_rst)
				endp_tx[i] <= ENDP_TX_RST;
			else if (usb_rst)
				endp_tx[i] <= ENDP_TX_RST;
			else
			begin
				if (reg_wr && (reg_addr == OFF_ENDP_TX0 + IDX))
					endp_tx[i] <= reg_wdata;
				if (setup_seen && (setup_endp == IDX))
					endp_tx[i][ETX_TOGGLE] <= 1'b1;
				else if (host_ack && (ack_endp == IDX))
					endp_tx[i][ETX_TOGGLE] <= !endp_tx[i][ETX_TOGGLE];
				if (good_ev && (xfer_endp == IDX) &&
					((xfer_token == TOKEN_IN) || (xfer_token == TOKEN_SETUP)))
					endp_tx[i][ETX_STATE_HI:ETX_STATE_LO] <= TX_NAK;
			end
		end
	end

	// ==================================================
	// handshake answer to in and out requests
	assign req_known = (req_endp < ENDP_COUNT);
	assign req_reg   = req_known ? endp_tx[req_endp] : 8'h00;

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hs_valid    <= 1'b0;
			hs_code     <= HS_NONE;
			tx_len      <= 4'h0;
			tx_data_pid <= 1'b0;
		end
		else
		begin
			hs_valid <= (in_req || out_req) && !usb_rst;
			if (usb_rst || !req_known)
				hs_code <= HS_NONE;
			else if (in_req)
			begin
				case (req_reg[ETX_STATE_HI:ETX_STATE_LO])
					TX_STALL: hs_code <= HS_STALL;
					TX_NAK:   hs_code <= HS_NAK;
					TX_VALID:
					begin
						if (event_flags[FLAG_GOOD_XFER])
							hs_code <= HS_NAK;
						else
							hs_code <= HS_DATA;
					end
					default:  hs_code <= HS_NONE;
				endcase
				tx_len      <= req_reg[3:0];
				tx_data_pid <= req_reg[ETX_TOGGLE];
			end
			else if (out_req)
			begin
				if (req_reg[ETX_STATUS_ONLY] && out_nonzero)
					hs_code <= HS_STALL;
				else
					hs_code <= HS_ACCEPT;
			end
		end
	end

	// ==================================================
	// register read port, data one cycle after the strobe
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				OFF_EVENT_FLAGS:  reg_rdata <= event_flags;
				OFF_EVENT_MASK:   reg_rdata <= event_mask;
				OFF_LINK_CONTROL: reg_rdata <= {4'h0, link_control};
				OFF_BUS_ID:       reg_rdata <= {1'b0, bus_id};
				3'h4:             reg_rdata <= endp_tx[0];
				3'h5:             reg_rdata <= endp_tx[1];
				3'h6:             reg_rdata <= endp_tx[2];
				OFF_TOKEN_INFO:   reg_rdata <= {token_type_bits, endpoint_number_bits, 4'h0};
				default:          reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

	// ==================================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_release_forced_reset;
		link_control[CTL_FORCED_RESET] ##1 !link_control[CTL_FORCED_RESET];
	endsequence

	sequence s_resume_pulse;
		link_control[CTL_RESUME] ##1 !link_control[CTL_RESUME];
	endsequence

	property p_sleep_req;
		check_on && idle_lvl && !usb_rst && !sleep_sent && (idle_cnt == IDLE_LIMIT)
		|=> event_flags[FLAG_SLEEP_REQ];
	endproperty
	a_sleep_req: assert property (p_sleep_req) else $error("sleep request not raised");

	property p_dma_late;
		dma_late |=> event_flags[FLAG_DMA_LATE];
	endproperty
	a_dma_late: assert property (p_dma_late) else $error("dma late flag missing");

	property p_good_kept;
		good_ev && !event_flags[FLAG_GOOD_XFER]
		|=> event_flags[FLAG_GOOD_XFER] && token_type_bits == $past(xfer_token)
			&& endpoint_number_bits == $past(xfer_endp);
	endproperty
	a_good_kept: assert property (p_good_kept) else $error("good transfer not recorded");

	property p_refused_not_good;
		xfer_done && xfer_refused && !event_flags[FLAG_GOOD_XFER]
		|=> !event_flags[FLAG_GOOD_XFER];
	endproperty
	a_refused_not_good: assert property (p_refused_not_good) else $error("refused counted good");

	property p_error_flag;
		err_ev |=> event_flags[FLAG_ERROR];
	endproperty
	a_error_flag: assert property (p_error_flag) else $error("error flag missing");

	property p_irq_overrun;
		(err_ev && event_flags[FLAG_ERROR]) || (frame_ev && event_flags[FLAG_FRAME])
		|=> event_flags[FLAG_IRQ_OVR];
	endproperty
	a_irq_overrun: assert property (p_irq_overrun) else $error("overrun flag missing");

	property p_wake;
		wake_ev |=> event_flags[FLAG_WAKE] && !forced_sleep ##1 !link_asleep;
	endproperty
	a_wake: assert property (p_wake) else $error("wake not handled");

	property p_forced_release;
		s_release_forced_reset |=> event_flags[FLAG_BUS_RESET];
	endproperty
	a_forced_release: assert property (p_forced_release) else $error("release flag missing");

	property p_reset_clears;
		usb_rst |=> bus_id == 7'h00 && endp_tx[0] == ENDP_TX_RST;
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("reset left state");

	property p_resume_frame;
		s_resume_pulse |=> event_flags[FLAG_FRAME];
	endproperty
	a_resume_frame: assert property (p_resume_frame) else $error("no frame flag at resume end");

	property p_irq;
		(|(event_flags & event_mask)) && !cpu_imask |=> irq_req;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt request missing");

	property p_no_sw_set;
		wr_flags && next_flags_set == 8'h00 |=> (event_flags & ~$past(event_flags)) == 8'h00;
	endproperty
	a_no_sw_set: assert property (p_no_sw_set) else $error("software set a flag");

	property p_status_stall;
		out_req && !in_req && req_known && !usb_rst && out_nonzero && req_reg[ETX_STATUS_ONLY]
		|=> hs_valid && hs_code == HS_STALL;
	endproperty
	a_status_stall: assert property (p_status_stall) else $error("status stage not stalled");

	property p_pending_nak;
		in_req && req_known && !usb_rst && event_flags[FLAG_GOOD_XFER]
		&& req_reg[ETX_STATE_HI:ETX_STATE_LO] == TX_VALID |=> hs_code == HS_NAK;
	endproperty
	a_pending_nak: assert property (p_pending_nak) else $error("valid endpoint not naked");

endmodule // usb_lowspeed_ctrl

// ### usb_host_model.sv
// host-side model of the low-speed bus as seen by the control block
`timescale 1ns/10ps
module usb_host_model
	import usb_lowspeed_pkg::*;
(
	input  wire logic       sys_clk,
	output logic            line_idle_pin,
	output logic            bus_reset_seen,
	output logic            keepalive_seen,
	output logic            dma_late,
	output logic            err_timeout,
	output logic            err_crc,
	output logic            err_stuff,
	output logic            err_framing,
	output logic            xfer_done,
	output logic [1:0]      xfer_token,
	output logic [1:0]      xfer_endp,
	output logic [4:0]      xfer_faults,
	output logic            xfer_toggle_ok,
	output logic            xfer_refused,
	output logic            setup_seen,
	output logic [1:0]      setup_endp,
	output logic            host_ack,
	output logic [1:0]      ack_endp,
	output logic            in_req,
	output logic            out_req,
	output logic [1:0]      req_endp,
	output logic            out_nonzero
);
	logic [6:0] ev_q;

	assign {bus_reset_seen, err_framing, err_stuff, err_crc, err_timeout, dma_late,
		keepalive_seen} = ev_q;

	initial
	begin
		ev_q = 7'h00;
		line_idle_pin = 1'b1;
		{xfer_done, xfer_token, xfer_endp, xfer_faults, xfer_toggle_ok, xfer_refused} = '0;
		{setup_seen, setup_endp, host_ack, ack_endp} = '0;
		{in_req, out_req, req_endp, out_nonzero} = '0;
	end

	// ========
	// bus events; released strobes drop to zero, other released fields show inverted values, never the last one
	task automatic line(input logic v);
		@(posedge sys_clk);
		line_idle_pin <= v;
	endtask

	task automatic ev(input logic [6:0] v);
		@(posedge sys_clk);
		ev_q <= v;
		@(posedge sys_clk);
		ev_q <= 7'h00;
	endtask

	task automatic req(input logic i, input logic o, input logic [1:0] ep, input logic nz);
		@(posedge sys_clk);
		{in_req, out_req, req_endp, out_nonzero} <= {i, o, ep, nz};
		@(posedge sys_clk);
		{in_req, out_req, req_endp, out_nonzero} <= {2'b00, ~ep, ~nz};
	endtask

	// the host sends a setup or an ack, so either one can move the data toggle
	task automatic tog(input logic s, input logic a, input logic [1:0] ep);
		@(posedge sys_clk);
		{setup_seen, host_ack, setup_endp, ack_endp} <= {s, a, ep, ep};
		@(posedge sys_clk);
		{setup_seen, host_ack, setup_endp, ack_endp} <= {2'b00, ~ep, ~ep};
	endtask

	task automatic xfer(input logic [1:0] tok, input logic [1:0] ep, input logic [4:0] f,
		input logic ok, input logic rf);
		@(posedge sys_clk);
		{xfer_done, xfer_token, xfer_endp, xfer_faults, xfer_toggle_ok, xfer_refused} <=
			{1'b1, tok, ep, f, ok, rf};
		@(posedge sys_clk);
		{xfer_done, xfer_token, xfer_endp, xfer_faults, xfer_toggle_ok, xfer_refused} <=
			{1'b0, ~tok, ~ep, ~f, ~ok, ~rf};
	endtask
endmodule // usb_host_model

// ### tb_top.sv
// self-checking bench of the usb event and transmit control block
`timescale 1ns/10ps
module tb_top
	import usb_lowspeed_pkg::*;
;
	logic       sys_clk, sys_rst, reg_wr, reg_rd, cpu_imask;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic       line_idle_pin, bus_reset_seen, keepalive_seen, dma_late, err_timeout;
	logic       err_crc, err_stuff, err_framing, xfer_done, xfer_toggle_ok, xfer_refused;
	logic       setup_seen, host_ack, in_req, out_req, out_nonzero, hs_valid, tx_data_pid;
	logic       irq_req, wake_irq, resume_drive, regulator_off, link_asleep, link_held_reset;
	logic [1:0] xfer_token, xfer_endp, setup_endp, ack_endp, req_endp;
	logic [4:0] xfer_faults;
	logic [3:0] tx_len;
	logic [6:0] bus_id;
	handshake_t hs_code;
	int         mismatches, comparisons;
	handshake_t hs_exp [4] = '{HS_NONE, HS_STALL, HS_NAK, HS_DATA};

	usb_lowspeed_ctrl #(.SLEEP_IDLE_CYCLES(20)) i_usb_lowspeed_ctrl (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_imask(cpu_imask),
		.line_idle_pin(line_idle_pin), .bus_reset_seen(bus_reset_seen),
		.keepalive_seen(keepalive_seen), .dma_late(dma_late), .err_timeout(err_timeout),
		.err_crc(err_crc), .err_stuff(err_stuff), .err_framing(err_framing),
		.xfer_done(xfer_done), .xfer_token(xfer_token), .xfer_endp(xfer_endp),
		.xfer_faults(xfer_faults), .xfer_toggle_ok(xfer_toggle_ok),
		.xfer_refused(xfer_refused), .setup_seen(setup_seen), .setup_endp(setup_endp),
		.host_ack(host_ack), .ack_endp(ack_endp), .in_req(in_req), .out_req(out_req),
		.req_endp(req_endp), .out_nonzero(out_nonzero), .hs_code(hs_code),
		.hs_valid(hs_valid), .tx_len(tx_len), .tx_data_pid(tx_data_pid),
		.irq_req(irq_req), .wake_irq(wake_irq), .resume_drive(resume_drive),
		.regulator_off(regulator_off), .link_asleep(link_asleep),
		.link_held_reset(link_held_reset), .bus_id(bus_id));
	usb_host_model i_usb_host_model (
		.sys_clk(sys_clk), .line_idle_pin(line_idle_pin), .bus_reset_seen(bus_reset_seen),
		.keepalive_seen(keepalive_seen), .dma_late(dma_late), .err_timeout(err_timeout),
		.err_crc(err_crc), .err_stuff(err_stuff), .err_framing(err_framing),
		.xfer_done(xfer_done), .xfer_token(xfer_token), .xfer_endp(xfer_endp),
		.xfer_faults(xfer_faults), .xfer_toggle_ok(xfer_toggle_ok),
		.xfer_refused(xfer_refused), .setup_seen(setup_seen), .setup_endp(setup_endp),
		.host_ack(host_ack), .ack_endp(ack_endp), .in_req(in_req), .out_req(out_req),
		.req_endp(req_endp), .out_nonzero(out_nonzero));

	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// ========
	// access and compare tasks
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_hs(input string n, input handshake_t e, input handshake_t g);
		comparisons++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s expected %0d seen %0d", n, e, g);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rc(input logic [2:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk($sformatf("reg %0d", a), e, reg_rdata);
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// the tests take about 300 cycles
	initial
	begin
		#400000;
		mismatches++;
		end_sim();
	end

	// ========
	// tests
	initial
	begin
		{sys_rst, cpu_imask} = 2'b11;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rc(OFF_EVENT_FLAGS, 8'h00);
		rc(OFF_EVENT_MASK, 8'h00);
		rc(OFF_LINK_CONTROL, 8'h06);
		rc(OFF_BUS_ID, 8'h00);
		for (int e = 0; e < ENDP_COUNT; e++)
			rc(OFF_ENDP_TX0 + 3'(e), 8'h00);
		repeat (40) @(posedge sys_clk);
		rc(OFF_EVENT_FLAGS, 8'h80);
		i_usb_host_model.line(1'b0);
		repeat (10) @(posedge sys_clk);
		rc(OFF_LINK_CONTROL, 8'h04);
		rc(OFF_EVENT_FLAGS, 8'h84);
		wr(OFF_EVENT_MASK, 8'h04);
		@(posedge sys_clk);
		#1 chk("wake_irq", 8'h01, {7'h0, wake_irq});
		chk("irq_req", 8'h00, {7'h0, irq_req});
		wr(OFF_EVENT_FLAGS, 8'h80);
		rc(OFF_EVENT_FLAGS, 8'h80);
		wr(OFF_EVENT_FLAGS, 8'hff);
		rc(OFF_EVENT_FLAGS, 8'h80);
		wr(OFF_EVENT_FLAGS, 8'h00);
		$display("test reset done");

		wr(OFF_EVENT_MASK, 8'h01);
		cpu_imask <= 1'b0;
		i_usb_host_model.ev(7'h01);
		@(posedge sys_clk);
		#1 chk("irq_req", 8'h01, {7'h0, irq_req});
		i_usb_host_model.ev(7'h01);
		i_usb_host_model.ev(7'h02);
		rc(OFF_EVENT_FLAGS, 8'h49);
		wr(OFF_EVENT_FLAGS, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			i_usb_host_model.ev(7'h04 << k);
			rc(OFF_EVENT_FLAGS, 8'h10);
			wr(OFF_EVENT_FLAGS, 8'h00);
		end
		$display("test events done");

		wr(OFF_LINK_CONTROL, 8'h0c);
		@(posedge sys_clk);
		#1 chk("ctl", 8'h03, {6'h0, resume_drive, regulator_off});
		wr(OFF_LINK_CONTROL, 8'h00);
		@(posedge sys_clk);
		#1 chk("ctl", 8'h00, {6'h0, resume_drive, regulator_off});
		rc(OFF_EVENT_FLAGS, 8'h01);
		wr(OFF_EVENT_FLAGS, 8'h00);
		wr(OFF_BUS_ID, 8'hff);
		rc(OFF_BUS_ID, 8'h7f);
		chk("bus_id", 8'h7f, {1'b0, bus_id});
		wr(OFF_LINK_CONTROL, 8'h01);
		@(posedge sys_clk);
		#1 chk("held", 8'h01, {7'h0, link_held_reset});
		rc(OFF_BUS_ID, 8'h00);
		rc(OFF_EVENT_FLAGS, 8'h00);
		wr(OFF_LINK_CONTROL, 8'h00);
		rc(OFF_EVENT_FLAGS, 8'h02);
		wr(OFF_EVENT_FLAGS, 8'h00);
		wr(OFF_BUS_ID, 8'h12);
		wr(OFF_ENDP_TX0, 8'h3f);
		i_usb_host_model.ev(7'h40);
		rc(OFF_BUS_ID, 8'h00);
		rc(OFF_ENDP_TX0, 8'h00);
		rc(OFF_EVENT_FLAGS, 8'h02);
		wr(OFF_EVENT_FLAGS, 8'h00);
		// let the synced idle level settle first, or the wake logic undoes the forced sleep
		i_usb_host_model.line(1'b1);
		repeat (6) @(posedge sys_clk);
		wr(OFF_LINK_CONTROL, 8'h02);
		repeat (30) @(posedge sys_clk);
		rc(OFF_EVENT_FLAGS, 8'h00);
		chk("asleep", 8'h01, {7'h0, link_asleep});
		i_usb_host_model.line(1'b0);
		repeat (8) @(posedge sys_clk);
		rc(OFF_LINK_CONTROL, 8'h00);
		rc(OFF_EVENT_FLAGS, 8'h04);
		wr(OFF_EVENT_FLAGS, 8'h00);
		$display("test control done");

		for (int s = 0; s < 4; s++)
		begin
			wr(OFF_ENDP_TX0 + 3'h1, {2'b00, 2'(s), 4'h5});
			i_usb_host_model.req(1'b1, 1'b0, 2'h1, 1'b0);
			#1 chk_hs("in", hs_exp[s], hs_code);
			chk("valid", 8'h01, {7'h0, hs_valid});
		end
		i_usb_host_model.req(1'b1, 1'b0, 2'h3, 1'b0);
		#1 chk_hs("in3", HS_NONE, hs_code);
		chk("len", 8'h05, {4'h0, tx_len});
		chk("pid", 8'h00, {7'h0, tx_data_pid});
		i_usb_host_model.tog(1'b1, 1'b0, 2'h1);
		rc(OFF_ENDP_TX0 + 3'h1, 8'h75);
		i_usb_host_model.tog(1'b0, 1'b1, 2'h1);
		rc(OFF_ENDP_TX0 + 3'h1, 8'h35);
		wr(OFF_ENDP_TX0 + 3'h2, 8'hb0);
		i_usb_host_model.req(1'b0, 1'b1, 2'h2, 1'b1);
		#1 chk_hs("out", HS_STALL, hs_code);
		i_usb_host_model.req(1'b0, 1'b1, 2'h2, 1'b0);
		#1 chk_hs("out", HS_ACCEPT, hs_code);
		wr(OFF_ENDP_TX0, 8'h33);
		i_usb_host_model.xfer(TOKEN_IN, 2'h0, 5'h00, 1'b1, 1'b0);
		rc(OFF_EVENT_FLAGS, 8'h20);
		rc(OFF_ENDP_TX0, 8'h23);
		rc(OFF_TOKEN_INFO, 8'h80);
		i_usb_host_model.req(1'b1, 1'b0, 2'h1, 1'b0);
		#1 chk_hs("in", HS_NAK, hs_code);
		wr(OFF_EVENT_FLAGS, 8'h00);
		i_usb_host_model.xfer(TOKEN_SETUP, 2'h1, 5'h00, 1'b1, 1'b0);
		rc(OFF_ENDP_TX0 + 3'h1, 8'h25);
		rc(OFF_TOKEN_INFO, 8'hd0);
		wr(OFF_EVENT_FLAGS, 8'h00);
		for (int b = 0; b < 3; b++)
		begin
			i_usb_host_model.xfer(TOKEN_OUT, 2'h2, b == 0 ? 5'h02 : 5'h00, b != 1, b == 2);
			rc(OFF_EVENT_FLAGS, 8'h00);
		end
		$display("test endpoints done");
		end_sim();
	end
endmodule // tb_top
